//--- dmc_pkg.sv
// Constants and types shared by the converter mode-control block.
// Assumes the serial word: read/write flag, 7-bit register index, 8-bit data.
package dmc_pkg;
	localparam logic [6:0] REG_LEFT_ATT  = 7'h10;
	localparam logic [6:0] REG_RIGHT_ATT = 7'h11;
	localparam logic [6:0] REG_FMT_CTRL  = 7'h12;
	localparam logic [6:0] REG_FILT_CTRL = 7'h13;
	localparam logic [6:0] REG_MODE_CTRL = 7'h14;
	localparam logic [6:0] REG_ZERO_STAT = 7'h15;

	// Register 0x12 fields
	localparam int F_LOAD    = 7;
	localparam int F_FMT_LSB = 4;
	localparam int F_DMF_LSB = 2;
	localparam int F_DME     = 1;
	localparam int F_MUTE    = 0;
	// Register 0x13 fields
	localparam int F_REV     = 7;
	localparam int F_ATS_LSB = 5;
	localparam int F_OPE     = 4;
	localparam int F_CLK_OUT_HALF_RATE    = 3;
	localparam int F_CLK_OUT_ENABLE    = 2;
	localparam int F_FLT     = 1;
	localparam int F_INFINITE_ZERO_MUTE    = 0;
	// Register 0x14 fields
	localparam int F_MODULATOR_ORDER_SEL    = 7;
	localparam int F_SYSTEM_RESET_BIT    = 6;
	localparam int F_REGISTER_RESET_BIT    = 5;
	localparam int F_FILTER_BYPASS    = 4;
	localparam int F_SINGLE_CHANNEL_MODE    = 3;
	localparam int F_SINGLE_CHANNEL_MODE_SOURCE_SEL    = 2;
	localparam int F_OS_LSB  = 0;

	localparam logic [7:0] ATT_RST       = 8'hFF;
	localparam logic [7:0] FMT_CTRL_RST  = 8'h00;
	localparam logic [7:0] FILT_CTRL_RST = 8'h04;
	localparam logic [7:0] MODE_CTRL_RST = 8'h00;
	localparam logic [7:0] SELF_CLR_MASK = 8'h60;
	localparam logic [7:0] ATT_MUTE_MAX  = 8'h0E;
	localparam logic [7:0] ATT_FLOOR     = 8'h00;
	localparam logic [2:0] FMT_RSV_MIN   = 3'h6;
	localparam logic [2:0] FMT_DEFAULT   = 3'h0;

	localparam logic [4:0] CMD_BITS   = 5'h08;
	localparam logic [4:0] FRAME_BITS = 5'h10;
	localparam int         RW_POS     = 7;
	localparam int         ZERO_RUN   = 1024;

	typedef enum logic [1:0] {PORT_IDLE, PORT_CMD, PORT_DATA, PORT_END} dmc_port_e;
	typedef enum logic [1:0] {SRC_NORMAL, SRC_BYPASS, SRC_ONEBIT} dmc_src_e;
endpackage

//--- dmc_buf2.sv
// Two-entry valid/ready buffer: an output register plus one skid entry.
// Assumes both sides run on clk_i; all outputs come from flip-flops.
`timescale 1ns/1ps
`default_nettype none
module dmc_buf2 #(
	parameter int W = 48
) (
	input  wire logic         clk_i,
	input  wire logic         resetn_i,
	input  wire logic         in_valid_i,
	output logic              in_ready_o,
	input  wire logic [W-1:0] in_data_i,
	output logic              out_valid_o,
	input  wire logic         out_ready_i,
	output logic [W-1:0]      out_data_o
);
	typedef struct packed {
		logic [W-1:0] head;
		logic         head_vld;
		logic [W-1:0] skid;
		logic         skid_vld;
		logic         rdy;
	} dmc_buf_s;

	dmc_buf_s st_r;
	dmc_buf_s st_nxt;

	if (W < 2) begin : g_chk
		$error("dmc_buf2: W must be at least 2");
	end

	always_comb begin
		st_nxt = st_r;
		if (st_r.head_vld && out_ready_i) begin
			st_nxt.head_vld = 1'b0;
		end
		if (!st_nxt.head_vld && st_r.skid_vld) begin
			st_nxt.head     = st_r.skid;
			st_nxt.head_vld = 1'b1;
			st_nxt.skid_vld = 1'b0;
		end
		if (in_valid_i && st_r.rdy) begin
			if (!st_nxt.head_vld) begin
				st_nxt.head     = in_data_i;
				st_nxt.head_vld = 1'b1;
			end else begin
				st_nxt.skid     = in_data_i;
				st_nxt.skid_vld = 1'b1;
			end
		end
		// Ready is registered, so a full skid entry refuses the next word
		st_nxt.rdy = !st_nxt.skid_vld;
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			st_r <= '{default: '0, rdy: 1'b1};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign in_ready_o  = st_r.rdy;
	assign out_valid_o = st_r.head_vld;
	assign out_data_o  = st_r.head;

	a_no_overflow: assert property (@(posedge clk_i) disable iff (!resetn_i)
		st_r.skid_vld |-> st_r.head_vld) else $error("skid full while head empty");
endmodule
`default_nettype wire

//--- dmc_mode_ctrl.sv
// Mode-control logic of a stereo converter: serial control port, mode
// registers, attenuation ramp, mute, zero detection and clock output.
// Assumes control pins, mute pin, mode pin and system clock are asynchronous;
// sample words arrive on clk_i from the audio deserialiser.
//
// Notes on behaviour
// RULE1: bypass bit routes filtered four-wire input
// RULE2: one-bit mode uses system clock pin
// RULE3: host holds word/bit clocks low then
// RULE4: zero flag after 1024 zero samples
// RULE5: infinite-zero mute when both channels zero
// RULE6: mute pin ramps outputs to zero
// RULE7: soft mute bit ramps outputs to zero
// RULE8: ramp speed field sets step rate
// RULE9: control port runs on its own clock
// RULE10: four control wires, select active low
// RULE11: flag one reads, zero writes
// RULE12: per-channel 8-bit attenuation, default 0dB
// RULE13: format field selects input format
// RULE14: emphasis enable and rate fields
// RULE15: rolloff, phase invert, converter disable bits
// RULE16: clock output enable and half rate
// RULE17: system and register reset bits act
// RULE18: oversampling rate and modulator order
// RULE19: single_channel_mode mode and source channel select
// RULE20: read-only zero flag status register
// RULE21: load enable gates attenuation writes
// RULE22: codes up to 14 mean mute
// RULE23: format codes 110 and 111 reserved
// RULE24: 16-bit word, flag, index, data
`timescale 1ns/1ps
`default_nettype none
module dmc_mode_ctrl
	import dmc_pkg::*;
#(
	parameter int SW       = 24,
	parameter int ZERO_LEN = ZERO_RUN
) (
	input  wire logic          clk_i,
	input  wire logic          resetn_i,
	input  wire logic          ctrl_serial_clock_i,
	input  wire logic          ctrl_select_n_i,
	input  wire logic          ctrl_serial_in_i,
	output logic               ctrl_serial_out_o,
	output logic               ctrl_serial_out_oe_o,
	input  wire logic          hw_mute_i,
	input  wire logic          onebit_mode_i,
	input  wire logic          system_clock_in_i,
	output logic               buffered_clock_out_o,
	input  wire logic          sample_valid_i,
	output logic               sample_ready_o,
	input  wire logic [SW-1:0] left_data_in_i,
	input  wire logic [SW-1:0] right_data_in_i,
	output logic               sample_valid_o,
	input  wire logic          sample_ready_i,
	output logic [SW-1:0]      left_sample_o,
	output logic [SW-1:0]      right_sample_o,
	output logic [7:0]         left_atten_code_o,
	output logic [7:0]         right_atten_code_o,
	output logic [1:0]         atten_mute_o,
	output logic               mute_active_o,
	output logic               left_zero_out_o,
	output logic               right_zero_out_o,
	output logic [2:0]         audio_format_sel_o,
	output logic               emphasis_enable_o,
	output logic [1:0]         emphasis_rate_sel_o,
	output logic               rolloff_sel_o,
	output logic               phase_invert_o,
	output logic               converter_disable_o,
	output logic               clk_out_enable_o,
	output logic [1:0]         oversample_rate_sel_o,
	output logic               modulator_order_sel_o,
	output logic               single_channel_mode_o,
	output logic               single_channel_mode_source_sel_o,
	output logic               filter_bypass_o,
	output dmc_src_e           source_mode_o,
	output logic               system_reset_o
);
	localparam int ZW = $clog2(ZERO_LEN + 1);
	localparam logic [ZW-1:0] ZERO_MAX = ZW'(ZERO_LEN);

	if (SW < 16 || SW > 32 || ZERO_LEN < 2) begin : g_chk
		$error("dmc_mode_ctrl: unsupported SW or ZERO_LEN");
	end

	typedef struct packed {
		logic [2:0]           mc_sy;
		logic [2:0]           cs_sy;
		logic [1:0]           mdi_sy;
		logic [1:0]           mute_sy;
		logic [1:0]           onebit_sy;
		logic [2:0]           sck_sy;
		dmc_port_e            port;
		logic [4:0]           bit_cnt;
		logic                 rd;
		logic [15:0]          shin;
		logic [7:0]           shout;
		logic                 ctrl_serial_out;
		logic                 mdo_oe;
		logic [7:0]           r16;
		logic [7:0]           r17;
		logic [7:0]           r18;
		logic [7:0]           r19;
		logic [7:0]           r20;
		logic [1:0][7:0]      applied;
		logic [1:0][7:0]      eff;
		logic [1:0][ZW-1:0]   zcnt;
		logic [1:0]           zflag;
		logic [1:0]           att_mute;
		logic [2:0]           tick_cnt;
		logic                 tick;
		logic                 mute_act;
		logic                 half;
		logic                 sck_out;
		logic                 sys_rst;
		logic [2:0]           fmt;
		dmc_src_e             src;
	} dmc_state_s;

	dmc_state_s    st_r;
	dmc_state_s    st_nxt;
	logic          wr_en;
	logic [6:0]    wr_idx;
	logic [7:0]    wr_dat;
	logic          acc;
	logic          muted;
	logic [2:0]    tmax;
	logic [15:0]   word;
	logic [7:0]    target;
	logic [SW-1:0] single_channel_mode_src;
	logic [SW-1:0] ch_l;
	logic [SW-1:0] ch_r;

	wire mc_rise = st_r.mc_sy[1] & ~st_r.mc_sy[2];
	wire mc_fall = ~st_r.mc_sy[1] & st_r.mc_sy[2];
	wire cs_act  = ~st_r.cs_sy[1];
	wire sck_up  = st_r.sck_sy[1] & ~st_r.sck_sy[2];

	function automatic logic [7:0] read_reg(input dmc_state_s s, input logic [6:0] idx);
		case (idx)
			REG_LEFT_ATT:  read_reg = s.r16;
			REG_RIGHT_ATT: read_reg = s.r17;
			REG_FMT_CTRL:  read_reg = s.r18;
			REG_FILT_CTRL: read_reg = s.r19;
			REG_MODE_CTRL: read_reg = s.r20;
			// RULE20: zero flags readback
			REG_ZERO_STAT: read_reg = {6'h00, s.zflag[1], s.zflag[0]};
			default:       read_reg = 8'h00;
		endcase
	endfunction

	// RULE19: single_channel_mode source selection
	always_comb begin
		single_channel_mode_src = st_r.r20[F_SINGLE_CHANNEL_MODE_SOURCE_SEL] ? right_data_in_i : left_data_in_i;
		ch_l     = st_r.r20[F_SINGLE_CHANNEL_MODE] ? single_channel_mode_src : left_data_in_i;
		ch_r     = st_r.r20[F_SINGLE_CHANNEL_MODE] ? single_channel_mode_src : right_data_in_i;
	end

	always_comb begin
		st_nxt           = st_r;
		wr_en            = 1'b0;
		word             = {st_r.shin[14:0], st_r.mdi_sy[1]};
		wr_idx           = word[14:8];
		wr_dat           = word[7:0];
		target           = ATT_FLOOR;
		st_nxt.mc_sy     = {st_r.mc_sy[1:0], ctrl_serial_clock_i};
		st_nxt.cs_sy     = {st_r.cs_sy[1:0], ctrl_select_n_i};
		st_nxt.mdi_sy    = {st_r.mdi_sy[0], ctrl_serial_in_i};
		st_nxt.mute_sy   = {st_r.mute_sy[0], hw_mute_i};
		st_nxt.onebit_sy = {st_r.onebit_sy[0], onebit_mode_i};
		st_nxt.sck_sy    = {st_r.sck_sy[1:0], system_clock_in_i};
		st_nxt.sys_rst   = 1'b0;

		// RULE9: port timed only by its own serial clock edges
		case (st_r.port)
			PORT_IDLE: begin
				st_nxt.mdo_oe = 1'b0;
				if (cs_act) begin
					st_nxt.port    = PORT_CMD;
					st_nxt.bit_cnt = 5'h00;
				end
			end
			PORT_CMD: begin
				if (!cs_act) begin
					st_nxt.port = PORT_IDLE;
				end else if (mc_rise) begin
					st_nxt.shin    = word;
					st_nxt.bit_cnt = st_r.bit_cnt + 5'h01;
					if (st_nxt.bit_cnt == CMD_BITS) begin
						st_nxt.port = PORT_DATA;
						// RULE11: flag one selects a read
						st_nxt.rd    = word[RW_POS];
						st_nxt.shout = read_reg(st_r, word[6:0]);
					end
				end
			end
			PORT_DATA: begin
				if (!cs_act) begin
					st_nxt.port   = PORT_IDLE;
					st_nxt.mdo_oe = 1'b0;
				end else begin
					// RULE10: readback shifted out on falling edges
					if (mc_fall && st_r.rd) begin
						st_nxt.ctrl_serial_out    = st_r.shout[7];
						st_nxt.shout  = {st_r.shout[6:0], 1'b0};
						st_nxt.mdo_oe = 1'b1;
					end
					if (mc_rise) begin
						st_nxt.shin    = word;
						st_nxt.bit_cnt = st_r.bit_cnt + 5'h01;
						// RULE24: write lands on the sixteenth bit
						if (st_nxt.bit_cnt == FRAME_BITS) begin
							st_nxt.port = PORT_END;
							wr_en       = !st_r.rd;
						end
					end
				end
			end
			PORT_END: begin
				// Last bit stays on the line until select rises
				if (!cs_act) begin
					st_nxt.port   = PORT_IDLE;
					st_nxt.mdo_oe = 1'b0;
				end
			end
			default: begin
				st_nxt.port   = PORT_IDLE;
				st_nxt.mdo_oe = 1'b0;
			end
		endcase

		if (wr_en) begin
			case (wr_idx)
				// RULE12: per-channel attenuation registers
				REG_LEFT_ATT: begin
					st_nxt.r16 = wr_dat;
					// RULE21: load enable gates the applied level
					if (st_r.r18[F_LOAD]) begin
						st_nxt.applied[0] = wr_dat;
					end
				end
				REG_RIGHT_ATT: begin
					st_nxt.r17 = wr_dat;
					if (st_r.r18[F_LOAD]) begin
						st_nxt.applied[1] = wr_dat;
					end
				end
				REG_FMT_CTRL:  st_nxt.r18 = wr_dat;
				REG_FILT_CTRL: st_nxt.r19 = wr_dat;
				REG_MODE_CTRL: begin
					st_nxt.r20 = wr_dat & ~SELF_CLR_MASK;
					// RULE17: reset bits start their action and self-clear
					if (wr_dat[F_REGISTER_RESET_BIT]) begin
						st_nxt.r16     = ATT_RST;
						st_nxt.r17     = ATT_RST;
						st_nxt.r18     = FMT_CTRL_RST;
						st_nxt.r19     = FILT_CTRL_RST;
						st_nxt.r20     = MODE_CTRL_RST;
						st_nxt.applied = {ATT_RST, ATT_RST};
					end
					st_nxt.sys_rst = wr_dat[F_SYSTEM_RESET_BIT];
				end
				default: ;
			endcase
		end

		// Sample side: zero runs and ramp ticks count accepted words
		acc         = sample_valid_i && sample_ready_o;
		tmax        = 3'((4'h1 << st_r.r19[F_ATS_LSB +: 2]) - 4'h1);
		st_nxt.tick = 1'b0;
		if (st_r.sys_rst) begin
			st_nxt.tick_cnt = 3'h0;
		end else if (acc) begin
			// RULE8: one step every 1, 2, 4 or 8 samples
			if (st_r.tick_cnt >= tmax) begin
				st_nxt.tick     = 1'b1;
				st_nxt.tick_cnt = 3'h0;
			end else begin
				st_nxt.tick_cnt = st_r.tick_cnt + 3'h1;
			end
		end

		for (int ch = 0; ch < 2; ch++) begin
			if (st_r.sys_rst) begin
				st_nxt.zcnt[ch]  = '0;
				st_nxt.zflag[ch] = 1'b0;
			end else if (acc) begin
				// RULE4: flag only after an unbroken zero run
				if ((ch == 0 ? left_data_in_i : right_data_in_i) == '0) begin
					if (st_r.zcnt[ch] != ZERO_MAX) begin
						st_nxt.zcnt[ch] = st_r.zcnt[ch] + ZW'(1);
					end
				end else begin
					st_nxt.zcnt[ch] = '0;
				end
				st_nxt.zflag[ch] = (st_nxt.zcnt[ch] == ZERO_MAX);
			end
		end

		// RULE6: mute pin
		// RULE7: soft mute bit
		// RULE5: both channels zero with the bit set
		muted = st_r.mute_sy[1] | st_r.r18[F_MUTE] | (st_r.r19[F_INFINITE_ZERO_MUTE] & (&st_r.zflag));
		st_nxt.mute_act = muted;
		for (int ch = 0; ch < 2; ch++) begin
			target = muted ? ATT_FLOOR : st_r.applied[ch];
			if (st_r.tick) begin
				if (st_r.eff[ch] > target) begin
					st_nxt.eff[ch] = st_r.eff[ch] - 8'h01;
				end else if (st_r.eff[ch] < target) begin
					st_nxt.eff[ch] = st_r.eff[ch] + 8'h01;
				end
			end
			// RULE22: low codes give full attenuation
			st_nxt.att_mute[ch] = (st_nxt.eff[ch] <= ATT_MUTE_MAX);
		end

		// RULE16: clock output; half rate toggles per rising input edge
		// Sampling at clk_i caps a faithful copy near half of clk_i
		if (sck_up) begin
			st_nxt.half = !st_r.half;
		end
		if (!st_r.r19[F_CLK_OUT_ENABLE]) begin
			st_nxt.sck_out = 1'b0;
		end else if (st_r.r19[F_CLK_OUT_HALF_RATE]) begin
			st_nxt.sck_out = st_r.half;
		end else begin
			st_nxt.sck_out = st_r.sck_sy[1];
		end

		// RULE13: format field passes to the deserialiser
		// RULE23: reserved codes fall back to the default format
		st_nxt.fmt = (st_r.r18[F_FMT_LSB +: 3] >= FMT_RSV_MIN) ?
			FMT_DEFAULT : st_r.r18[F_FMT_LSB +: 3];

		// RULE2: one-bit mode takes the system clock pin as bit clock
		// RULE1: bypass takes the filtered four-wire port
		if (st_r.onebit_sy[1]) begin
			st_nxt.src = SRC_ONEBIT;
		end else if (st_r.r20[F_FILTER_BYPASS]) begin
			st_nxt.src = SRC_BYPASS;
		end else begin
			st_nxt.src = SRC_NORMAL;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			st_r <= '{mc_sy: 3'h0, cs_sy: 3'h7, port: PORT_IDLE, r16: ATT_RST, r17: ATT_RST,
				r18: FMT_CTRL_RST, r19: FILT_CTRL_RST, r20: MODE_CTRL_RST,
				applied: {ATT_RST, ATT_RST}, eff: {ATT_RST, ATT_RST}, src: SRC_NORMAL,
				fmt: FMT_DEFAULT, default: '0};
		end else begin
			st_r <= st_nxt;
		end
	end

	dmc_buf2 #(
		.W(2 * SW)
	) u_buf (
		.clk_i       (clk_i),
		.resetn_i    (resetn_i),
		.in_valid_i  (sample_valid_i),
		.in_ready_o  (sample_ready_o),
		.in_data_i   ({ch_l, ch_r}),
		.out_valid_o (sample_valid_o),
		.out_ready_i (sample_ready_i),
		.out_data_o  ({left_sample_o, right_sample_o})
	);

	assign ctrl_serial_out_o     = st_r.ctrl_serial_out;
	assign ctrl_serial_out_oe_o  = st_r.mdo_oe;
	assign buffered_clock_out_o  = st_r.sck_out;
	assign left_atten_code_o     = st_r.eff[0];
	assign right_atten_code_o    = st_r.eff[1];
	assign atten_mute_o          = st_r.att_mute;
	assign mute_active_o         = st_r.mute_act;
	assign left_zero_out_o       = st_r.zflag[0];
	assign right_zero_out_o      = st_r.zflag[1];
	assign audio_format_sel_o    = st_r.fmt;
	// RULE14: emphasis controls
	assign emphasis_enable_o     = st_r.r18[F_DME];
	assign emphasis_rate_sel_o   = st_r.r18[F_DMF_LSB +: 2];
	// RULE15: filter and output controls
	assign rolloff_sel_o         = st_r.r19[F_FLT];
	assign phase_invert_o        = st_r.r19[F_REV];
	assign converter_disable_o   = st_r.r19[F_OPE];
	assign clk_out_enable_o      = st_r.r19[F_CLK_OUT_ENABLE];
	// RULE18: modulator settings
	assign oversample_rate_sel_o = st_r.r20[F_OS_LSB +: 2];
	assign modulator_order_sel_o = st_r.r20[F_MODULATOR_ORDER_SEL];
	assign single_channel_mode_o = st_r.r20[F_SINGLE_CHANNEL_MODE];
	assign single_channel_mode_source_sel_o     = st_r.r20[F_SINGLE_CHANNEL_MODE_SOURCE_SEL];
	assign filter_bypass_o       = st_r.r20[F_FILTER_BYPASS];
	assign source_mode_o         = st_r.src;
	assign system_reset_o        = st_r.sys_rst;

	a_left_att_write: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE12
		wr_en && wr_idx == REG_LEFT_ATT |=> st_r.r16 == $past(wr_dat))
		else $error("left attenuation write lost");
	a_att_load_hold: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE21
		wr_en && !st_r.r18[F_LOAD] && wr_idx != REG_MODE_CTRL |=> $stable(st_r.applied))
		else $error("applied level changed with load disabled");
	a_zero_flag_run: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE4
		$rose(st_r.zflag[0]) |-> $past(st_r.zcnt[0]) == ZERO_MAX - ZW'(1))
		else $error("zero flag set before the full run");
	a_zero_flag_drop: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE20
		acc && left_data_in_i != '0 |=> !st_r.zflag[0] && st_r.zcnt[0] == '0)
		else $error("zero flag kept after nonzero sample");
	a_pin_mute_ramp: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE6
		st_r.mute_sy[1] && st_r.tick && st_r.eff[0] != ATT_FLOOR
		|=> st_r.eff[0] == $past(st_r.eff[0]) - 8'h01)
		else $error("mute pin did not ramp down");
	a_soft_mute_act: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE7
		st_r.r18[F_MUTE] |=> st_r.mute_act)
		else $error("soft mute not applied");
	a_inf_zero_mute: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE5
		st_r.r19[F_INFINITE_ZERO_MUTE] && (&st_r.zflag) |=> st_r.mute_act)
		else $error("infinite zero mute not applied");
	a_ramp_spacing: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE8
		st_r.tick |-> $past(st_r.tick_cnt) == $past(tmax) && $past(acc))
		else $error("ramp tick at wrong sample");
	a_read_no_write: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE11
		st_r.port == PORT_DATA && st_r.rd |-> !wr_en)
		else $error("read frame wrote a register");
	a_mdo_release: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE10
		!cs_act && st_r.port != PORT_IDLE |=> !st_r.mdo_oe)
		else $error("readback still driven after deselect");
	a_mode_reset: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE17
		wr_en && wr_idx == REG_MODE_CTRL && wr_dat[F_REGISTER_RESET_BIT]
		|=> st_r.r18 == FMT_CTRL_RST ##1 st_r.r20 == MODE_CTRL_RST)
		else $error("register reset not applied");
	a_bypass_route: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE1
		st_r.r20[F_FILTER_BYPASS] && !st_r.onebit_sy[1] |=> st_r.src == SRC_BYPASS)
		else $error("bypass route not selected");
endmodule
`default_nettype wire

//--- dmc_host.sv
// Host model driving the serial control port of the mode-control block.
// Assumes clk_i is the bench clock; the link clock stands low between frames.
`timescale 1ns/1ps
`default_nettype none
module dmc_host (
	input  wire logic clk_i,
	output logic      sclk_o,
	output logic      sel_n_o,
	output logic      sdi_o,
	input  wire logic sdo_i
);
	initial begin
		sclk_o = 1'b0;
		sel_n_o = 1'b1;
		sdi_o = 1'b0;
	end
	// own clock, flag, index, data, MSB first
	task automatic xfer(input logic [15:0] w, output logic [7:0] rd);
		@(posedge clk_i);
		#1 sel_n_o = 1'b0;
		#80;
		for (int i = 15; i >= 0; i--) begin
			sdi_o = w[i];
			#80 sclk_o = 1'b1;
			if (i < 8)
				rd[i] = sdo_i;
			#80 sclk_o = 1'b0;
		end
		#80 sel_n_o = 1'b1;
		// Released data line must not keep a stale bit
		sdi_o = ~sdi_o;
		#160;
	endtask
endmodule
`default_nettype wire

//--- tb.sv
// Self-checking bench for the converter mode-control block.
// Assumes a 50 MHz clk_i and the host model on the control port.
`timescale 1ns/1ps
`default_nettype none
module tb;
	import dmc_pkg::*;
	logic clk_i = 1'b0, resetn_i = 1'b0, hw_mute_i = 1'b0, onebit_mode_i = 1'b0;
	logic system_clock_in_i = 1'b0, sample_valid_i = 1'b0, sample_ready_i = 1'b1;
	logic [23:0] left_data_in_i = 24'h0, right_data_in_i = 24'h0;
	logic ctrl_serial_clock_i, ctrl_select_n_i, ctrl_serial_in_i;
	logic ctrl_serial_out_o, ctrl_serial_out_oe_o, buffered_clock_out_o;
	logic sample_ready_o, sample_valid_o, mute_active_o, left_zero_out_o;
	logic right_zero_out_o, emphasis_enable_o, rolloff_sel_o, phase_invert_o;
	logic converter_disable_o, clk_out_enable_o, modulator_order_sel_o;
	logic single_channel_mode_o, single_channel_mode_source_sel_o, filter_bypass_o, system_reset_o;
	logic [23:0] left_sample_o, right_sample_o;
	logic [7:0] left_atten_code_o, right_atten_code_o, rd;
	logic [1:0] atten_mute_o, emphasis_rate_sel_o, oversample_rate_sel_o;
	logic [2:0] audio_format_sel_o;
	dmc_src_e source_mode_o;
	int miscompares = 0;
	int check_count = 0;
	int system_reset_bit_seen = 0;
	// Undriven readback pin shows the inverse of its last level
	wire logic sdo_line = ctrl_serial_out_oe_o ? ctrl_serial_out_o : ~ctrl_serial_out_o;
	always #10 clk_i = ~clk_i;
	always #35 system_clock_in_i = ~system_clock_in_i;
	always @(posedge clk_i)
		if (system_reset_o === 1'b1)
			system_reset_bit_seen++;
	dmc_host host_i (.clk_i, .sclk_o(ctrl_serial_clock_i), .sel_n_o(ctrl_select_n_i),
		.sdi_o(ctrl_serial_in_i), .sdo_i(sdo_line));
	dmc_mode_ctrl #(.SW(24), .ZERO_LEN(8)) dmc_mode_ctrl_i (.clk_i, .resetn_i,
		.ctrl_serial_clock_i, .ctrl_select_n_i, .ctrl_serial_in_i, .ctrl_serial_out_o,
		.ctrl_serial_out_oe_o, .hw_mute_i, .onebit_mode_i, .system_clock_in_i,
		.buffered_clock_out_o, .sample_valid_i, .sample_ready_o, .left_data_in_i,
		.right_data_in_i, .sample_valid_o, .sample_ready_i, .left_sample_o, .right_sample_o,
		.left_atten_code_o, .right_atten_code_o, .atten_mute_o, .mute_active_o,
		.left_zero_out_o, .right_zero_out_o, .audio_format_sel_o, .emphasis_enable_o,
		.emphasis_rate_sel_o, .rolloff_sel_o, .phase_invert_o, .converter_disable_o,
		.clk_out_enable_o, .oversample_rate_sel_o, .modulator_order_sel_o,
		.single_channel_mode_o, .single_channel_mode_source_sel_o, .filter_bypass_o, .source_mode_o,
		.system_reset_o);
	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input string n, input logic [47:0] e, input logic [47:0] s);
		check_count++;
		if (s !== e) begin
			miscompares++;
			$display("wrong value %s expected %0h seen %0h", n, e, s);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		host_i.xfer({1'b0, a, d}, rd);
	endtask
	task automatic rchk(input logic [6:0] a, input logic [7:0] e);
		host_i.xfer({1'b1, a, 8'h00}, rd);
		chk("readback", e, rd);
	endtask
	task automatic send(input int n, input logic [23:0] l, input logic [23:0] r);
		int got;
		got = 0;
		@(posedge clk_i);
		#1 left_data_in_i = l;
		right_data_in_i = r;
		sample_valid_i = 1'b1;
		for (int b = 0; b < 4 * n + 20 && got < n; b++) begin
			if (sample_ready_o === 1'b1)
				got++;
			tick(1);
		end
		sample_valid_i = 1'b0;
		if (got < n) begin
			miscompares++;
			close_out();
		end
	endtask
	task automatic clk_rate(input logic [7:0] cfg, input int lo, input int hi);
		int n;
		logic last;
		n = 0;
		wr(REG_FILT_CTRL, cfg);
		last = buffered_clock_out_o;
		for (int i = 0; i < 35; i++) begin
			tick(1);
			n += int'(buffered_clock_out_o !== last);
			last = buffered_clock_out_o;
		end
		chk("clk out edges", 1'b1, n >= lo && n <= hi);
	endtask
	task automatic t_defaults();
		rchk(REG_LEFT_ATT, 8'hFF);
		rchk(REG_RIGHT_ATT, 8'hFF);
		rchk(REG_FMT_CTRL, 8'h00);
		rchk(REG_FILT_CTRL, 8'h04);
		rchk(REG_MODE_CTRL, 8'h00);
		rchk(7'h30, 8'h00);
		chk("clk out enable", 1'b1, clk_out_enable_o);
		chk("oe after frames", 1'b0, ctrl_serial_out_oe_o);
		clk_rate(8'h04, 16, 24);
		clk_rate(8'h0C, 7, 13);
		$display("test defaults done");
	endtask
	task automatic t_fields();
		for (int f = 0; f < 8; f++) begin
			wr(REG_FMT_CTRL, {1'b0, 3'(f), 2'(f), 2'b10});
			chk("format", (f < 6) ? f : 0, audio_format_sel_o);
			chk("emphasis", {2'(f), 1'b1}, {emphasis_rate_sel_o, emphasis_enable_o});
		end
		rchk(REG_FMT_CTRL, 8'h7E);
		rchk(REG_FMT_CTRL, 8'h7E);
		wr(REG_FILT_CTRL, 8'hF3);
		chk("filt", 4'hD, {phase_invert_o, converter_disable_o, clk_out_enable_o, rolloff_sel_o});
		chk("clk out off", 1'b0, buffered_clock_out_o);
		wr(REG_MODE_CTRL, 8'h8E);
		chk("mode", 5'h1E, {modulator_order_sel_o, single_channel_mode_o, single_channel_mode_source_sel_o,
			oversample_rate_sel_o});
		sample_ready_i = 1'b0;
		send(2, 24'h000111, 24'h000222);
		chk("full", 2'b01, {sample_ready_o, sample_valid_o});
		chk("single_channel_mode", 48'h000222000222, {left_sample_o, right_sample_o});
		sample_ready_i = 1'b1;
		tick(4);
		chk("drained", 1'b0, sample_valid_o);
		wr(REG_MODE_CTRL, 8'h10);
		chk("bypass", {1'b1, SRC_BYPASS}, {filter_bypass_o, source_mode_o});
		// bench drives no word or bit clock, so both stay low
		onebit_mode_i = 1'b1;
		tick(4);
		chk("onebit", SRC_ONEBIT, source_mode_o);
		onebit_mode_i = 1'b0;
		wr(REG_MODE_CTRL, 8'h20);
		rchk(REG_FILT_CTRL, 8'h04);
		rchk(REG_MODE_CTRL, 8'h00);
		wr(REG_MODE_CTRL, 8'h40);
		chk("sys reset", 1, system_reset_bit_seen);
		wr(REG_ZERO_STAT, 8'hFF);
		rchk(REG_ZERO_STAT, 8'h00);
		$display("test fields done");
	endtask
	task automatic t_atten();
		wr(REG_LEFT_ATT, 8'h80);
		send(140, 24'h1, 24'h1);
		chk("left atten held", 8'hFF, left_atten_code_o);
		rchk(REG_LEFT_ATT, 8'h80);
		wr(REG_FMT_CTRL, 8'h80);
		wr(REG_RIGHT_ATT, 8'h0E);
		send(250, 24'h1, 24'h1);
		chk("right atten", 8'h0E, right_atten_code_o);
		chk("atten mute", 2'b10, atten_mute_o);
		wr(REG_FILT_CTRL, 8'h24);
		wr(REG_FMT_CTRL, 8'h81);
		chk("soft mute", 1'b1, mute_active_o);
		send(20, 24'h1, 24'h1);
		tick(3);
		chk("ramp half rate", 8'hF5, left_atten_code_o);
		wr(REG_FMT_CTRL, 8'h80);
		hw_mute_i = 1'b1;
		tick(4);
		chk("pin mute", 1'b1, mute_active_o);
		send(4, 24'h1, 24'h1);
		tick(3);
		chk("pin mute ramp", 8'hF3, left_atten_code_o);
		hw_mute_i = 1'b0;
		tick(4);
		chk("pin unmute", 1'b0, mute_active_o);
		$display("test atten done");
	endtask
	task automatic t_zero();
		send(7, 24'h0, 24'h0);
		chk("zero early", 2'b00, {right_zero_out_o, left_zero_out_o});
		send(1, 24'h0, 24'h0);
		tick(2);
		chk("zero set", 2'b11, {right_zero_out_o, left_zero_out_o});
		rchk(REG_ZERO_STAT, 8'h03);
		chk("no zero mute", 1'b0, mute_active_o);
		wr(REG_FILT_CTRL, 8'h05);
		chk("zero mute", 1'b1, mute_active_o);
		send(1, 24'h5, 24'h0);
		tick(4);
		chk("zero left clr", 2'b10, {right_zero_out_o, left_zero_out_o});
		chk("zero mute off", 1'b0, mute_active_o);
		$display("test zero done");
	endtask
	initial begin
		repeat (6) @(posedge clk_i);
		#1 resetn_i = 1'b1;
		tick(2);
		t_defaults();
		t_fields();
		t_atten();
		t_zero();
		close_out();
	end
endmodule
`default_nettype wire
